// *** logic/power_clock_regs.vh ***
// Register map, field positions and reset values of the power and clock gating block.
`ifndef POWER_CLOCK_REGS_VH
`define POWER_CLOCK_REGS_VH

`define PWR_ADDR_W            4
`define CLK_DIV_REG_ADDR      4'h0
`define GATE_ONE_REG_ADDR     4'h1
`define PWR_STATUS_REG_ADDR   4'h2

`define CLK_DIV_RETURN_BIT    15
`define CLK_DIV_RATIO_HI      14
`define CLK_DIV_RATIO_LO      12
`define CLK_DIV_SLOW_BIT      11
`define CLK_DIV_WMASK         16'hF800
`define CLK_DIV_RESET         16'h0000

`define GATE_ONE_WMASK        16'hFEFF
`define GATE_ONE_RESET        16'h0000
`define GATE_PRESENT_DEFAULT  16'hFEFF

`define GATE_TIMER5_BIT       15
`define GATE_TIMER4_BIT       14
`define GATE_TIMER3_BIT       13
`define GATE_TIMER2_BIT       12
`define GATE_TIMER1_BIT       11
`define GATE_ENCODER_BIT      10
`define GATE_MOTOR_PWM_BIT    9
`define GATE_I2C_ONE_BIT      7
`define GATE_UART_TWO_BIT     6
`define GATE_UART_ONE_BIT     5
`define GATE_SPI_TWO_BIT      4
`define GATE_SPI_ONE_BIT      3
`define GATE_CAN_TWO_BIT      2
`define GATE_CAN_ONE_BIT      1
`define GATE_CONV_ONE_BIT     0

`define DIV_COUNT_W           7

`endif

// *** logic/cpu_slow_divider.v ***
// Divides the CPU clock enable by a power of two during doze.
`timescale 1ns/1ps
`include "power_clock_regs.vh"

module cpu_slow_divider (
    input  wire                     clk,
    input  wire                     reset_n,
    input  wire                     slow_en,
    input  wire [2:0]               ratio,
    output reg                      tick_q
);

    reg  [`DIV_COUNT_W-1:0] count_q;
    reg  [`DIV_COUNT_W-1:0] count_d;
    wire [`DIV_COUNT_W-1:0] limit;
    wire                    tick_d;

    // Code n yields a limit of two to the n minus one.
    assign limit  = (7'h01 << ratio) - 7'h01;
    // A disabled divider ticks every cycle, so the CPU runs at full rate.
    assign tick_d = !slow_en || (count_q >= limit);

    always @* begin
        if (tick_d) begin
            count_d = {`DIV_COUNT_W{1'b0}};
        end else begin
            count_d = count_q + 7'h01;
        end
    end

    // The tick is an enable on the system clock, so CPU and peripherals stay in step.
    always @(posedge clk) begin
        if (!reset_n) begin
            count_q <= {`DIV_COUNT_W{1'b0}};
            tick_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q  <= tick_d;
        end
    end

endmodule // cpu_slow_divider

// *** logic/power_clock_ctrl.v ***
// Power-save modes, doze divider control and peripheral clock gating.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "power_clock_regs.vh"

module power_clock_ctrl #(
    parameter [15:0] PERIPH_PRESENT = `GATE_PRESENT_DEFAULT
) (
    input  wire                     clk,
    input  wire                     reset_n,
    input  wire [`PWR_ADDR_W-1:0]   addr,
    input  wire [15:0]              wdata,
    input  wire                     wr_en,
    input  wire                     rd_en,
    output reg  [15:0]              rdata_q,
    input  wire                     power_save_instruction,
    input  wire                     power_save_sleep,
    input  wire                     irq_req,
    output reg                      cpu_clk_en_q,
    output reg                      sys_clk_run_q,
    output reg                      irq_hold_q,
    output reg                      wake_q,
    output reg  [15:0]              periph_clk_en_q,
    output reg  [15:0]              periph_sfr_en_q,
    output reg                      analog_digital_force_q
);

    localparam [1:0] ST_RUN   = 2'b00;
    localparam [1:0] ST_ENTER = 2'b01;
    localparam [1:0] ST_IDLE  = 2'b10;
    localparam [1:0] ST_SLEEP = 2'b11;

    reg  [15:0] clock_divider_register_q;
    reg  [15:0] clock_divider_register_d;
    reg  [15:0] peripheral_clock_gate_one_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg         mode_sleep_q;
    reg         held_q;
    reg         held_d;
    reg         irq_prev_q;
    wire        irq_event;
    wire        cpu_slow_enable;
    wire        return_on_interrupt;
    wire [2:0]  slow_ratio;
    wire        div_tick;
    wire [15:0] gate_enable;

    function sel;
        input [`PWR_ADDR_W-1:0] a;
        input [`PWR_ADDR_W-1:0] target;
        begin
            sel = (a == target);
        end
    endfunction

    assign irq_event           = irq_req && !irq_prev_q;
    assign cpu_slow_enable     = clock_divider_register_q[`CLK_DIV_SLOW_BIT];
    assign return_on_interrupt = clock_divider_register_q[`CLK_DIV_RETURN_BIT];
    assign slow_ratio          = clock_divider_register_q[`CLK_DIV_RATIO_HI:`CLK_DIV_RATIO_LO];

    cpu_slow_divider u_div (
        .clk     (clk),
        .reset_n (reset_n),
        .slow_en (cpu_slow_enable),
        .ratio   (slow_ratio),
        .tick_q  (div_tick)
    );

    // Divider register: software write, then the hardware return-on-interrupt clear.
    always @* begin
        clock_divider_register_d = clock_divider_register_q;
        if (wr_en && sel(addr, `CLK_DIV_REG_ADDR)) begin
            clock_divider_register_d = wdata & `CLK_DIV_WMASK;
        end
        // Without the return bit, interrupts leave doze alone.
        if (irq_event && clock_divider_register_d[`CLK_DIV_RETURN_BIT]) begin
            clock_divider_register_d[`CLK_DIV_SLOW_BIT] = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            clock_divider_register_q    <= `CLK_DIV_RESET;
            peripheral_clock_gate_one_q <= `GATE_ONE_RESET;
            irq_prev_q                  <= 1'b0;
        end else begin
            clock_divider_register_q <= clock_divider_register_d;
            irq_prev_q               <= irq_req;
            if (wr_en && sel(addr, `GATE_ONE_REG_ADDR)) begin
                // Bit 8 is not stored and reads back as zero.
                peripheral_clock_gate_one_q <= wdata & `GATE_ONE_WMASK;
            end
        end
    end

    // Power-save sequencer.
    always @* begin
        state_d = state_q;
        held_d  = held_q;
        case (state_q)
            ST_RUN: begin
                if (power_save_instruction) begin
                    state_d = ST_ENTER;
                    // A coincident interrupt is parked, not serviced.
                    held_d  = irq_event;
                end
            end
            ST_ENTER: begin
                if (irq_event) begin
                    held_d = 1'b1;
                end
                state_d = mode_sleep_q ? ST_SLEEP : ST_IDLE;
            end
            ST_IDLE, ST_SLEEP: begin
                // Entry is complete here, so a parked interrupt wakes at once.
                if (held_q || irq_event) begin
                    state_d = ST_RUN;
                    held_d  = 1'b0;
                end
            end
            default: begin
                state_d = ST_RUN;
                held_d  = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            state_q      <= ST_RUN;
            held_q       <= 1'b0;
            mode_sleep_q <= 1'b0;
            irq_hold_q   <= 1'b0;
            wake_q       <= 1'b0;
        end else begin
            state_q    <= state_d;
            held_q     <= held_d;
            irq_hold_q <= held_d || (state_d == ST_ENTER);
            wake_q     <= (state_q != ST_RUN) && (state_q != ST_ENTER) && (state_d == ST_RUN);
            if (state_q == ST_RUN && power_save_instruction) begin
                mode_sleep_q <= power_save_sleep;
            end
        end
    end

    // Clock enables. Doze touches only the CPU enable; system and peripherals stay full rate.
    always @(posedge clk) begin
        if (!reset_n) begin
            cpu_clk_en_q  <= 1'b0;
            sys_clk_run_q <= 1'b1;
        end else begin
            cpu_clk_en_q  <= (state_d == ST_RUN) && div_tick;
            sys_clk_run_q <= (state_d != ST_SLEEP);
        end
    end

    // Per-peripheral gating; absent peripherals never run whatever their bit holds.
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_gate
            // Gate bit i serves peripheral i: timers, encoder, PWM, serial units, converter.
            assign gate_enable[i] = !peripheral_clock_gate_one_q[i] && PERIPH_PRESENT[i];

            // The gate bit lands at the write edge and the enable one cycle after it.
            always @(posedge clk) begin
                if (!reset_n) begin
                    periph_clk_en_q[i] <= 1'b0;
                    periph_sfr_en_q[i] <= 1'b0;
                end else begin
                    // Sleep removes the system clock from every peripheral; Idle keeps it.
                    periph_clk_en_q[i] <= gate_enable[i] && (state_d != ST_SLEEP);
                    // Register writes to a gated peripheral must be dropped by it.
                    periph_sfr_en_q[i] <= gate_enable[i];
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (!reset_n) begin
            analog_digital_force_q <= 1'b0;
        end else begin
            // Converter gated means pins shared with analog inputs run digital.
            analog_digital_force_q <= !gate_enable[`GATE_CONV_ONE_BIT];
        end
    end

    // Read port: data stand in the cycle after the strobe, zero elsewhere and when unmapped.
    always @(posedge clk) begin
        if (!reset_n) begin
            rdata_q <= 16'h0000;
        end else if (rd_en) begin
            if (sel(addr, `CLK_DIV_REG_ADDR)) begin
                rdata_q <= clock_divider_register_q;
            end else if (sel(addr, `GATE_ONE_REG_ADDR)) begin
                rdata_q <= peripheral_clock_gate_one_q;
            end else if (sel(addr, `PWR_STATUS_REG_ADDR)) begin
                rdata_q <= {11'h000, held_q, cpu_slow_enable, mode_sleep_q, state_q};
            end else begin
                rdata_q <= 16'h0000;
            end
        end else begin
            rdata_q <= 16'h0000;
        end
    end

endmodule // power_clock_ctrl

// *** verif/power_clock_props.sv ***
// Port-level assertions of the power and clock gating block.
`timescale 1ns/1ps
module power_clock_props #(
    parameter [15:0] PERIPH_PRESENT = 16'hFEFF
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [15:0] rdata_q,
    input wire logic        power_save_instruction,
    input wire logic        power_save_sleep,
    input wire logic        irq_req,
    input wire logic        cpu_clk_en_q,
    input wire logic        sys_clk_run_q,
    input wire logic        irq_hold_q,
    input wire logic        wake_q,
    input wire logic [15:0] periph_clk_en_q,
    input wire logic [15:0] periph_sfr_en_q,
    input wire logic        analog_digital_force_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence gate_write; wr_en && addr == 4'h1; endsequence
    sequence save_with_irq; power_save_instruction && irq_req && !$past(irq_req); endsequence
    sequence save_sleep; power_save_instruction && power_save_sleep && !irq_req; endsequence
    sequence save_idle; power_save_instruction && !power_save_sleep && !irq_req; endsequence
    chk_gate_delay: assert property (gate_write ##1 1'b1 |=>
        periph_sfr_en_q == (~$past(wdata, 2) & PERIPH_PRESENT)) else $error("gate delay wrong");
    chk_absent_off: assert property (((periph_sfr_en_q | periph_clk_en_q) & ~PERIPH_PRESENT)
        == 16'h0000) else $error("absent unit enabled");
    chk_analog_digital: assert property ($past(reset_n) |->
        analog_digital_force_q == !periph_sfr_en_q[0]) else $error("analog force wrong");
    chk_irq_held: assert property (save_with_irq |=> irq_hold_q ##1 !wake_q ##1
        (wake_q && !irq_hold_q)) else $error("held interrupt wrong");
    chk_sleep_stops: assert property (save_sleep |=> !cpu_clk_en_q ##1
        (!sys_clk_run_q && periph_clk_en_q == 16'h0000)) else $error("sleep wrong");
    chk_idle_cpu: assert property (save_idle |=> ##1 (sys_clk_run_q && !cpu_clk_en_q &&
        periph_clk_en_q == periph_sfr_en_q)) else $error("idle wrong");
    chk_stopped_all: assert property (!sys_clk_run_q |-> !cpu_clk_en_q &&
        periph_clk_en_q == 16'h0000) else $error("clock left running");
    chk_wake_clocks: assert property (wake_q |-> sys_clk_run_q &&
        periph_clk_en_q == periph_sfr_en_q) else $error("wake clocks wrong");
    chk_read_idle: assert property (!rd_en |=> rdata_q == 16'h0000) else $error("read data stuck");
    chk_read_unmapped: assert property (rd_en && addr > 4'h2 |=> rdata_q == 16'h0000)
        else $error("unmapped read");
    chk_bit8_zero: assert property (rd_en && addr == 4'h1 |=> !rdata_q[8])
        else $error("bit 8 set");
endmodule // power_clock_props

bind power_clock_ctrl power_clock_props #(.PERIPH_PRESENT(PERIPH_PRESENT)) u_props (.clk,
    .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata_q, .power_save_instruction,
    .power_save_sleep, .irq_req, .cpu_clk_en_q, .sys_clk_run_q, .irq_hold_q, .wake_q,
    .periph_clk_en_q, .periph_sfr_en_q, .analog_digital_force_q);

// *** verif/cpu_irq_model.sv ***
// Stand-in for the CPU core: raises interrupts and counts its clock enables.
`timescale 1ns/1ps
module cpu_irq_model (
    input  wire logic clk,
    input  wire logic cpu_clk_en,
    input  wire logic fire,
    output logic      irq_req = 1'b0,
    output int        tick_count = 0
);
    // Both outputs start from a known value, so the design never sees an unknown request.
    always @(posedge clk)
        irq_req <= fire;
    // One instruction per enable, so the count exposes the doze ratio.
    always @(posedge clk)
        if (cpu_clk_en)
            tick_count <= tick_count + 1;
endmodule // cpu_irq_model

// *** verif/testbench.sv ***
// Self-checking testbench of the power and clock gating block.
`timescale 1ns/1ps
`include "power_clock_regs.vh"
module testbench;
    logic        clk = 0;
    logic        reset_n = 0;
    logic [3:0]  addr = 0;
    logic [15:0] wdata = 0;
    logic        wr_en = 0;
    logic        rd_en = 0;
    logic        pws = 0;
    logic        sleep = 0;
    logic        fire = 0;
    logic [15:0] r;
    wire  [15:0] rdata, pclk, psfr;
    wire         cpu_en, sys_run, hold, wake, irq, force_dig;
    int          ticks, t0, fail_count = 0, samples_checked = 0;
    power_clock_ctrl i_power_clock_ctrl (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata),
        .power_save_instruction(pws), .power_save_sleep(sleep), .irq_req(irq),
        .cpu_clk_en_q(cpu_en), .sys_clk_run_q(sys_run), .irq_hold_q(hold), .wake_q(wake),
        .periph_clk_en_q(pclk), .periph_sfr_en_q(psfr), .analog_digital_force_q(force_dig));
    cpu_irq_model i_cpu_irq_model (.clk(clk), .cpu_clk_en(cpu_en), .fire(fire),
        .irq_req(irq), .tick_count(ticks));
    initial forever #2 clk = ~clk;
    task chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        rd_en <= 1;
        addr <= a;
        @(posedge clk);
        rd_en <= 0;
        #1 r = rdata;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // The interrupt stays pending two cycles, long enough to be seen as one event.
    task pulse_irq;
        @(posedge clk);
        fire <= 1;
        tick(2);
        fire <= 0;
        tick(2);
    endtask
    task t_reset;
        rd(4'h0);
        chk16(r, 16'h0000);
        rd(4'h1);
        chk16(r, 16'h0000);
        chk16(psfr, `GATE_PRESENT_DEFAULT);
        rd(4'hF);
        chk16(r, 16'h0000);
        $display("test reset done");
    endtask
    task t_gates;
        for (int i = 0; i < 16; i++) begin
            wr(4'h1, 16'h0001 << i);
            #1 chk16(psfr, `GATE_PRESENT_DEFAULT);
            tick(1);
            chk16(psfr, ~(16'h0001 << i) & `GATE_PRESENT_DEFAULT);
            chk16(pclk, psfr);
            chk16(force_dig, i == 0);
            rd(4'h1);
            chk16(r, (16'h0001 << i) & `GATE_PRESENT_DEFAULT);
            wr(4'h1, 16'h0000);
            tick(1);
            chk16(psfr, `GATE_PRESENT_DEFAULT);
        end
        $display("test gates done");
    endtask
    task t_doze;
        for (int n = 0; n < 9; n++) begin
            wr(4'h0, (n < 8) ? (16'h0800 | (n << 12)) : 16'h7000);
            tick(300);
            t0 = ticks;
            tick(256);
            chk16(16'(ticks - t0), (n < 8) ? (256 >> n) : 256);
            chk16(pclk, `GATE_PRESENT_DEFAULT);
        end
        $display("test doze done");
    endtask
    task t_roi;
        wr(4'h0, 16'h2800);
        pulse_irq;
        rd(4'h0);
        chk16(r, 16'h2800);
        wr(4'h0, 16'hA800);
        pulse_irq;
        rd(4'h0);
        chk16(r, 16'hA000);
        wr(4'h0, 16'h0000);
        $display("test return done");
    endtask
    task t_save(input logic s);
        @(posedge clk);
        pws <= 1;
        sleep <= s;
        @(posedge clk);
        pws <= 0;
        tick(2);
        chk16(sys_run, !s);
        chk16(pclk, s ? 16'h0000 : `GATE_PRESENT_DEFAULT);
        chk16(cpu_en, 0);
        pulse_irq;
        chk16(sys_run, 1);
    endtask
    task t_power;
        t_save(0);
        t_save(1);
        @(posedge clk);
        fire <= 1;
        @(posedge clk);
        pws <= 1;
        sleep <= 1;
        @(posedge clk);
        pws <= 0;
        fire <= 0;
        #1 chk16(hold, 1);
        tick(1);
        chk16(sys_run, 0);
        tick(1);
        chk16(wake, 1);
        $display("test power save done");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        t_reset;
        t_gates;
        t_doze;
        t_roi;
        t_power;
        wrap_up;
    end
    // About 5200 cycles are needed; the margin covers a slow doze setting.
    initial begin
        #100000;
        fail_count++;
        wrap_up;
    end
endmodule // testbench
